/* hw/acr_regs.svh */
`ifndef ACR_REGS_SVH
`define ACR_REGS_SVH

// Register byte offsets, low address byte only
`define ACR_OFF_STATUS    8'h00
`define ACR_OFF_RES_HIGH  8'h04
`define ACR_OFF_RES_LOW   8'h08
`define ACR_OFF_CLK_CFG   8'h0C
`define ACR_ADDR_DEC      7:0

// Status and control fields
`define ACR_STS_FLAG      7
`define ACR_STS_IRQ_EN    6
`define ACR_STS_CONT      5
`define ACR_STS_CHAN      4:0
`define ACR_STS_RESET     8'h1F

// Clock configuration fields
`define ACR_CLK_DIV       7:5
`define ACR_CLK_SRC       4
`define ACR_CLK_MODE      3:2
`define ACR_CLK_RESET     8'h04
`define ACR_CLK_DIV_RESET 3'h0

// Channel codes
`define ACR_CH_POWER_OFF  5'h1F
`define ACR_CH_PIN_LAST   5'h07
`define ACR_CH_TEST       5'h1B
`define ACR_CH_REF_HIGH   5'h1D
`define ACR_CH_REF_LOW    5'h1E

// Converter clock periods in one conversion
`define ACR_CONV_TICKS    5'h10
// Prescaler terminal count for the divide by 16 setting
`define ACR_DIV16_LAST    4'hF

`endif

/* hw/acr_pkg.sv */
package acr_pkg;

   typedef enum logic [1:0] {
      acr_mode_trunc8      = 2'b00,
      acr_mode_right       = 2'b01,
      acr_mode_left        = 2'b10,
      acr_mode_left_signed = 2'b11
   } acr_mode_t;

   typedef enum logic [1:0] {
      acr_idle    = 2'b00,
      acr_sync    = 2'b01,
      acr_convert = 2'b10
   } acr_state_t;

endpackage

/* hw/acr_div_if.sv */
`timescale 1ns/1ps
interface acr_div_if;
   logic       osc_tick;
   logic       src_bus;
   logic [2:0] prescale;
   logic       conv_tick;

   modport ctl (output osc_tick, output src_bus, output prescale, input conv_tick);
   modport div (input osc_tick, input src_bus, input prescale, output conv_tick);
endinterface

/* hw/acr_clkdiv.sv */
`timescale 1ns/1ps
`include "acr_regs.svh"
module acr_clkdiv (
   // Clock and reset
   input  wire logic clk_in,
   input  wire logic rst_b_in,
   // Divider controls and tick
   acr_div_if.div    div_if
);

   logic [3:0] cnt_reg;
   logic [3:0] cnt_next;
   logic       tick_reg;

   function automatic logic [3:0] div_last(input logic [2:0] sel);
      logic [3:0] one;
      one = 4'h1;
      if (sel[2])
         div_last = `ACR_DIV16_LAST;
      else
         div_last = 4'((one << sel[1:0]) - one);
   endfunction

   // Input clock is the bus clock or the oscillator tick
   wire       src_tick = div_if.src_bus | div_if.osc_tick;
   wire [3:0] last     = div_last(div_if.prescale);
   wire       wrap     = src_tick & (cnt_reg >= last);

   assign cnt_next = wrap ? 4'h0 : (src_tick ? 4'(cnt_reg + 4'h1) : cnt_reg);
   assign div_if.conv_tick = tick_reg;

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         cnt_reg  <= 4'h0;
         tick_reg <= 1'b0;
      end else begin
         cnt_reg  <= cnt_next;
         tick_reg <= wrap;
      end
   end

   div_one_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      (div_if.src_bus && div_if.prescale == 3'h0) |=> div_if.conv_tick)
      else $error("Divide by one on bus clock missed a tick");

endmodule

/* hw/acr_top.sv */
// Behaviour
// - Status write aborts and restarts conversion
// - Flag sets per conversion; continuous: first only
// - Flag clears on status write or data read
// - Interrupt enabled: flag is plain read/write
// - Interrupt request at end; read/write clears
// - Reset clears interrupt enable
// - Continuous bit repeats conversions; else one
// - Five-bit channel code, pins zero to seven
// - All-ones channel powers converter off
// - Reference, test and unknown channel codes
// - First conversion after power-up is discarded
// - Left format: eight high, two low
// - Right format: two high, eight low
// - Signed left format inverts result msb
// - Truncation: low holds eight msbs, no interlock
// - High read freezes low until low read
// - Prescaler divides by 1,2,4,8,16
// - Source bit: bus clock or oscillator
// - Justification codes; reset gives right format
// - Conversion lasts 16 to 17 converter clocks
// - Continuous results overwrite unread results
//
// The register addresses and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
`include "acr_regs.svh"
module acr_top (
   // Clock and reset
   input  wire logic        clk_in,
   input  wire logic        rst_b_in,
   // AHB-Lite slave
   input  wire logic        hsel_in,
   input  wire logic [31:0] haddr_in,
   input  wire logic [1:0]  htrans_in,
   input  wire logic        hwrite_in,
   input  wire logic [2:0]  hsize_in,
   input  wire logic [31:0] hwdata_in,
   input  wire logic        hready_in,
   output logic      [31:0] hrdata_out,
   output logic             hreadyout_out,
   output logic             hresp_out,
   // External oscillator clock as a one-cycle tick
   input  wire logic        ext_osc_tick_in,
   // Analog core
   output logic             conv_start_out,
   output logic      [4:0]  conv_channel_out,
   output logic             conv_tick_out,
   output logic             conv_power_down_out,
   input  wire logic [9:0]  conv_result_in,
   input  wire logic        conv_done_in,
   // Interrupt request
   output logic             irq_req_out
);

   // Bus data phase state
   logic                   wr_pend_reg;
   logic [7:0]             wr_addr_reg;
   logic                   rd_pend_reg;
   logic [7:0]             rd_addr_reg;
   logic [31:0]            hrdata_reg;

   // Status and control register fields
   logic                   flag_reg;
   logic                   flag_next;
   logic                   irq_en_reg;
   logic                   cont_reg;
   logic [4:0]             chan_reg;

   // Clock configuration fields
   logic [2:0]             div_reg;
   logic                   src_reg;
   acr_pkg::acr_mode_t     mode_reg;

   // Sequencer and result state
   acr_pkg::acr_state_t    state_reg;
   acr_pkg::acr_state_t    state_next;
   logic [4:0]             tick_cnt_reg;
   logic [4:0]             tick_cnt_next;
   logic                   start_reg;
   logic                   warm_reg;
   logic                   first_reg;
   logic                   lock_reg;
   logic                   lock_next;
   logic                   irq_reg;
   logic                   irq_next;
   logic [9:0]             raw_reg;

   acr_div_if div_if ();

   acr_clkdiv u_div (
      .clk_in   (clk_in),
      .rst_b_in (rst_b_in),
      .div_if   (div_if.div)
   );

   assign div_if.osc_tick = ext_osc_tick_in;
   assign div_if.src_bus  = src_reg;
   assign div_if.prescale = div_reg;
   wire   conv_tick       = div_if.conv_tick;

   // Result formatting for the high byte
   function automatic logic [7:0] fmt_high(input logic [9:0] raw,
                                           input acr_pkg::acr_mode_t mode);
      case (mode)
         acr_pkg::acr_mode_trunc8:      fmt_high = 8'h00;
         acr_pkg::acr_mode_right:       fmt_high = {6'h00, raw[9:8]};
         acr_pkg::acr_mode_left:        fmt_high = raw[9:2];
         acr_pkg::acr_mode_left_signed: fmt_high = {~raw[9], raw[8:2]};
         default:                       fmt_high = 8'h00;
      endcase
   endfunction

   // Result formatting for the low byte
   function automatic logic [7:0] fmt_low(input logic [9:0] raw,
                                          input acr_pkg::acr_mode_t mode);
      case (mode)
         acr_pkg::acr_mode_trunc8: fmt_low = raw[9:2];
         acr_pkg::acr_mode_right:  fmt_low = raw[7:0];
         default:                  fmt_low = {raw[1:0], 6'h00};
      endcase
   endfunction

   // Address phase acceptance
   wire addr_ok   = hsel_in & htrans_in[1] & hready_in;
   wire wr_accept = addr_ok & hwrite_in;
   wire rd_accept = addr_ok & ~hwrite_in;
   wire [7:0] wd  = hwdata_in[7:0];

   // Write strobes in the data phase
   wire wr_sts = wr_pend_reg & (wr_addr_reg == `ACR_OFF_STATUS);
   wire wr_clk = wr_pend_reg & (wr_addr_reg == `ACR_OFF_CLK_CFG);

   // Read side effects take place when the read data is captured
   wire rd_high = rd_pend_reg & (rd_addr_reg == `ACR_OFF_RES_HIGH);
   wire rd_low  = rd_pend_reg & (rd_addr_reg == `ACR_OFF_RES_LOW);
   wire data_rd = rd_high | rd_low;

   wire [7:0] sts_word = {flag_reg, irq_en_reg, cont_reg, chan_reg};
   wire [7:0] clk_word = {div_reg, src_reg, mode_reg, 2'b00};
   wire [7:0] rd_byte;
   assign rd_byte =
      (rd_addr_reg == `ACR_OFF_STATUS)   ? sts_word :
      (rd_addr_reg == `ACR_OFF_RES_HIGH) ? fmt_high(raw_reg, mode_reg) :
      (rd_addr_reg == `ACR_OFF_RES_LOW)  ? fmt_low(raw_reg, mode_reg) :
      (rd_addr_reg == `ACR_OFF_CLK_CFG)  ? clk_word : 8'h00;

   // One wait state on reads, none on writes
   assign hreadyout_out = ~rd_pend_reg;
   assign hresp_out     = 1'b0;
   assign hrdata_out    = hrdata_reg;

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
         rd_pend_reg <= 1'b0;
         rd_addr_reg <= 8'h00;
         hrdata_reg  <= 32'h0000_0000;
      end else begin
         wr_pend_reg <= wr_accept;
         rd_pend_reg <= rd_accept;
         if (wr_accept)
            wr_addr_reg <= haddr_in[`ACR_ADDR_DEC];
         if (rd_accept)
            rd_addr_reg <= haddr_in[`ACR_ADDR_DEC];
         if (rd_pend_reg)
            hrdata_reg <= {24'h00_0000, rd_byte};
      end
   end

   // Channel decode
   wire new_off   = wd[`ACR_STS_CHAN] == `ACR_CH_POWER_OFF;
   wire power_off = chan_reg == `ACR_CH_POWER_OFF;
   // Reference, test and unused codes are resolved by the analog mux
   assign conv_channel_out    = chan_reg;
   assign conv_power_down_out = power_off;
   assign conv_start_out      = start_reg;
   assign conv_tick_out       = conv_tick;

   // Conversion end after the full count of converter clocks
   wire conv_end    = (state_reg == acr_pkg::acr_convert) & conv_done_in &
                      (tick_cnt_reg == `ACR_CONV_TICKS);
   wire conv_end_ok = conv_end & ~warm_reg;
   wire store       = conv_end_ok & ~lock_reg;

   // Flag and interrupt set conditions
   wire flag_set = conv_end_ok & ~irq_en_reg & (~cont_reg | first_reg);
   wire irq_set  = conv_end_ok & irq_en_reg;

   always_comb begin
      if (flag_set)
         flag_next = 1'b1;
      else if (wr_sts)
         flag_next = wd[`ACR_STS_IRQ_EN] & wd[`ACR_STS_FLAG];
      else if (data_rd & ~irq_en_reg)
         flag_next = 1'b0;
      else
         flag_next = flag_reg;
   end

   always_comb begin
      if (irq_set)
         irq_next = 1'b1;
      else if (wr_sts | data_rd)
         irq_next = 1'b0;
      else
         irq_next = irq_reg;
   end

   // High read locks the low byte except in truncation format
   always_comb begin
      if (rd_high & (mode_reg != acr_pkg::acr_mode_trunc8))
         lock_next = 1'b1;
      else if (rd_low | (mode_reg == acr_pkg::acr_mode_trunc8))
         lock_next = 1'b0;
      else
         lock_next = lock_reg;
   end

   // Sequencer
   always_comb begin
      state_next = state_reg;
      if (wr_sts)
         state_next = new_off ? acr_pkg::acr_idle : acr_pkg::acr_sync;
      else if (power_off)
         state_next = acr_pkg::acr_idle;
      else begin
         case (state_reg)
            acr_pkg::acr_sync: begin
               if (conv_tick)
                  state_next = acr_pkg::acr_convert;
            end
            acr_pkg::acr_convert: begin
               // A discarded settling conversion is always followed by another
               if (conv_end)
                  state_next = (cont_reg | warm_reg) ? acr_pkg::acr_sync :
                                                       acr_pkg::acr_idle;
            end
            default: begin
               state_next = acr_pkg::acr_idle;
            end
         endcase
      end
   end

   always_comb begin
      if (state_reg != acr_pkg::acr_convert)
         tick_cnt_next = 5'h00;
      else if (conv_tick & (tick_cnt_reg < `ACR_CONV_TICKS))
         tick_cnt_next = 5'(tick_cnt_reg + 5'h01);
      else
         tick_cnt_next = tick_cnt_reg;
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         flag_reg     <= 1'b0;
         irq_en_reg   <= 1'b0;
         cont_reg     <= 1'b0;
         chan_reg     <= `ACR_CH_POWER_OFF;
         state_reg    <= acr_pkg::acr_idle;
         tick_cnt_reg <= 5'h00;
         start_reg    <= 1'b0;
         irq_reg      <= 1'b0;
         lock_reg     <= 1'b0;
         first_reg    <= 1'b0;
      end else begin
         flag_reg     <= flag_next;
         state_reg    <= state_next;
         tick_cnt_reg <= tick_cnt_next;
         start_reg    <= (state_reg == acr_pkg::acr_sync) & conv_tick & ~wr_sts;
         irq_reg      <= irq_next;
         lock_reg     <= lock_next;
         if (wr_sts) begin
            irq_en_reg <= wd[`ACR_STS_IRQ_EN];
            cont_reg   <= wd[`ACR_STS_CONT];
            chan_reg   <= wd[`ACR_STS_CHAN];
            first_reg  <= 1'b1;
         end else if (conv_end_ok)
            first_reg  <= 1'b0;
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         div_reg  <= `ACR_CLK_DIV_RESET;
         src_reg  <= 1'b0;
         mode_reg <= acr_pkg::acr_mode_right;
      end else if (wr_clk) begin
         div_reg  <= wd[`ACR_CLK_DIV];
         src_reg  <= wd[`ACR_CLK_SRC];
         mode_reg <= acr_pkg::acr_mode_t'(wd[`ACR_CLK_MODE]);
      end
   end

   // Settling state and result store
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         warm_reg <= 1'b1;
         raw_reg  <= 10'h000;
      end else begin
         if (power_off)
            warm_reg <= 1'b1;
         else if (conv_end)
            warm_reg <= 1'b0;
         if (store)
            raw_reg <= conv_result_in;
      end
   end

   assign irq_req_out = irq_reg;

   default clocking acr_cb @(posedge clk_in);
   endclocking
   default disable iff (!rst_b_in);

   wr_restart_a: assert property (
      (wr_sts && !new_off) |=> (state_reg == acr_pkg::acr_sync) && !conv_start_out)
      else $error("Status write did not restart conversion");

   flag_single_a: assert property (
      (conv_end_ok && !irq_en_reg && !cont_reg) |=> flag_reg)
      else $error("Single conversion end did not set flag");

   flag_wr_clr_a: assert property (
      (wr_sts && !wd[`ACR_STS_IRQ_EN] && !flag_set) |=> !flag_reg)
      else $error("Status write did not clear flag");

   flag_rw_a: assert property (
      (wr_sts && wd[`ACR_STS_IRQ_EN] && !flag_set) |=> flag_reg == $past(wd[`ACR_STS_FLAG]))
      else $error("Flag not writable with interrupt enabled");

   irq_raise_a: assert property (
      (conv_end_ok && irq_en_reg) |=> irq_req_out [*1] ##1 (irq_req_out || $past(wr_sts || data_rd)))
      else $error("Interrupt request not raised at conversion end");

   irq_clear_a: assert property (
      ((wr_sts || data_rd) && !irq_set) |=> !irq_req_out)
      else $error("Interrupt request not removed");

   ctl_reset_a: assert property (
      $rose(rst_b_in) |-> !irq_en_reg && !cont_reg && mode_reg == acr_pkg::acr_mode_right)
      else $error("Control fields wrong after reset");

   cont_repeat_a: assert property (
      (conv_end && cont_reg && !wr_sts && !power_off) |=> state_reg == acr_pkg::acr_sync)
      else $error("Continuous mode did not restart");

   power_off_a: assert property (
      (power_off && !wr_sts) |=> state_reg == acr_pkg::acr_idle && !conv_start_out)
      else $error("Converter active while powered off");

   warm_drop_a: assert property (
      (conv_end && warm_reg) |=> $stable(raw_reg) && state_reg != acr_pkg::acr_convert)
      else $error("Settling conversion result was kept");

   trunc_high_a: assert property (
      (rd_high && mode_reg == acr_pkg::acr_mode_trunc8) |=> hrdata_out == 32'h0000_0000)
      else $error("High byte not zero in truncation format");

   lock_hold_a: assert property (
      (lock_reg && !rd_low) |=> $stable(raw_reg))
      else $error("Result changed while low byte locked");

   conv_len_a: assert property (
      $rose(state_reg == acr_pkg::acr_convert) |-> !conv_end [*2])
      else $error("Conversion ended too early");

endmodule

/* verif/acr_core_model.sv */
`timescale 1ns/1ps
module acr_core_model (
   // Clock and reset
   input  wire logic       clk_in,
   input  wire logic       rst_b_in,
   // From the control logic
   input  wire logic       start_in,
   input  wire logic       tick_in,
   input  wire logic       power_down_in,
   // From the bench
   input  wire logic [9:0] raw_in,
   input  wire logic [7:0] extra_in,
   // To the control logic and bench
   output logic            done_out,
   output logic      [9:0] result_out,
   output logic      [7:0] n_start_out
);
   logic       busy_reg;
   logic [4:0] ticks_reg;
   logic [7:0] wait_reg;
   wire        last = busy_reg && ticks_reg == 5'h10 && wait_reg >= extra_in;

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         busy_reg    <= 1'b0;
         ticks_reg   <= 5'h00;
         wait_reg    <= 8'h00;
         done_out    <= 1'b0;
         result_out  <= 10'h000;
         n_start_out <= 8'h00;
      end else begin
         done_out   <= last;
         // Result lines wander outside the done cycle
         result_out <= last ? raw_in : ~result_out;
         if (power_down_in) begin
            busy_reg <= 1'b0;
         end else if (start_in) begin
            busy_reg    <= 1'b1;
            ticks_reg   <= 5'h00;
            wait_reg    <= 8'h00;
            n_start_out <= n_start_out + 8'h01;
         end else if (last) begin
            busy_reg <= 1'b0;
         end else if (ticks_reg != 5'h10) begin
            ticks_reg <= ticks_reg + {4'h0, tick_in};
         end else begin
            wait_reg <= wait_reg + 8'h01;
         end
      end
   end
endmodule

/* verif/adc_control_result_regs_tb.sv */
`timescale 1ns/1ps
`include "acr_regs.svh"
module adc_control_result_regs_tb;
   localparam logic [31:0] a_st   = {24'h00_0000, `ACR_OFF_STATUS};
   localparam logic [31:0] a_hi   = {24'h00_0000, `ACR_OFF_RES_HIGH};
   localparam logic [31:0] a_lo   = {24'h00_0000, `ACR_OFF_RES_LOW};
   localparam logic [31:0] a_ck   = {24'h00_0000, `ACR_OFF_CLK_CFG};
   localparam logic [7:0]  ck_rst = {4'h0, acr_pkg::acr_mode_right, 2'b00};
   logic        clk_in, rst_b_in, hsel, hwrite, s_rdy, s_sel, s_wr;
   logic        osc = 1'b0, dph = 1'b0;
   logic [1:0]  htrans;
   logic [1:0]  osc_cnt = 2'h0;
   logic [31:0] haddr, hwdata, s_dat;
   logic [9:0]  raw;
   logic [7:0]  extra, n;
   logic [15:0] v;
   logic [4:0]  codes[4] = '{5'h07, 5'h1B, 5'h1D, 5'h1E};
   logic [31:0] expq[$];
   wire  [31:0] hrdata;
   wire  [9:0]  res;
   wire  [7:0]  nst;
   wire  [4:0]  chan;
   wire         hready, hresp, start, tick, pdown, done, irq;
   int          seed = 72550;
   int          n_mismatch = 0;
   int          n_compared = 0;
   int          cyc = 0;

   acr_top dut (
      .clk_in              (clk_in),
      .rst_b_in            (rst_b_in),
      .hsel_in             (hsel),
      .haddr_in            (haddr),
      .htrans_in           (htrans),
      .hwrite_in           (hwrite),
      .hsize_in            (3'b010),
      .hwdata_in           (hwdata),
      .hready_in           (hready),
      .hrdata_out          (hrdata),
      .hreadyout_out       (hready),
      .hresp_out           (hresp),
      .ext_osc_tick_in     (osc),
      .conv_start_out      (start),
      .conv_channel_out    (chan),
      .conv_tick_out       (tick),
      .conv_power_down_out (pdown),
      .conv_result_in      (res),
      .conv_done_in        (done),
      .irq_req_out         (irq)
   );

   acr_core_model core (
      .clk_in        (clk_in),
      .rst_b_in      (rst_b_in),
      .start_in      (start),
      .tick_in       (tick),
      .power_down_in (pdown),
      .raw_in        (raw),
      .extra_in      (extra),
      .done_out      (done),
      .result_out    (res),
      .n_start_out   (nst)
   );

   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end

   // Oscillator tick every third cycle, well above the minimum rate
   always @(posedge clk_in) begin
      osc_cnt <= osc_cnt == 2'h2 ? 2'h0 : osc_cnt + 2'h1;
      osc     <= osc_cnt == 2'h2;
   end

   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         stop_test();
      end
   end

   task automatic stop_test();
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic cmp(string nm, logic [31:0] e, logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Read data checked against the oldest note when its data phase ends
   always @(negedge clk_in) begin
      s_rdy = hready;
      s_sel = hsel & htrans[1];
      s_wr  = hwrite;
      s_dat = hrdata;
   end
   always @(posedge clk_in) begin
      if (dph && s_rdy)
         cmp("read data", expq.pop_front(), s_dat);
      if (s_rdy)
         dph = s_sel && !s_wr;
   end

   task automatic pins(logic pd, logic [4:0] ch, logic iq);
      @(negedge clk_in);
      cmp("power down", 32'(pd), 32'(pdown));
      cmp("channel", 32'(ch), 32'(chan));
      cmp("irq", 32'(iq), 32'(irq));
      cmp("response", 32'h0000_0000, 32'(hresp));
      @(posedge clk_in);
   endtask

   task automatic wait_rdy();
      logic r;
      do begin
         @(negedge clk_in);
         r = hready;
         @(posedge clk_in);
      end while (r !== 1'b1);
   endtask

   task automatic bus(logic w, logic [31:0] a, logic [31:0] d);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      haddr  <= a;
      hwrite <= w;
      wait_rdy();
      htrans <= 2'b00;
      hwdata <= d;
      wait_rdy();
   endtask

   task automatic rd(logic [31:0] a, logic [7:0] e);
      expq.push_back({24'h00_0000, e});
      bus(1'b0, a, 32'h0000_0000);
   endtask

   task automatic wr(logic [31:0] a, logic [7:0] d);
      bus(1'b1, a, {24'h00_0000, d});
   endtask

   task automatic wait_done(int k);
      @(posedge clk_in);
      while (k > 0) begin
         @(negedge clk_in);
         if (done === 1'b1)
            k--;
         @(posedge clk_in);
      end
   endtask

   task automatic gap(int e);
      int c = 0;
      repeat (2) do @(negedge clk_in); while (tick !== 1'b1);
      do begin
         @(negedge clk_in);
         c++;
      end while (tick !== 1'b1);
      cmp("tick spacing", e, c);
      @(posedge clk_in);
   endtask

   function automatic logic [15:0] fmt(logic [1:0] m, logic [9:0] r);
      case (m)
         2'b00:   fmt = {8'h00, r[9:2]};
         2'b01:   fmt = {6'h00, r};
         2'b10:   fmt = {r, 6'h00};
         default: fmt = {~r[9], r[8:0], 6'h00};
      endcase
   endfunction

   initial begin
      {hsel, hwrite, htrans, haddr, hwdata, raw, extra} = '0;
      rst_b_in = 1'b0;
      repeat (20) @(posedge clk_in);
      rst_b_in <= 1'b1;
      @(posedge clk_in);
      rd(a_st, 8'h1F);
      rd(a_ck, ck_rst);
      rd(a_hi, 8'h00);
      rd(a_lo, 8'h00);
      rd(32'h0000_0010, 8'h00);
      pins(1'b1, 5'h1F, 1'b0);
      for (int m = 0; m < 4; m++) begin
         raw <= 10'($random(seed));
         wr(a_ck, {4'h1, 2'(m), 2'b00});
         wr(a_st, {3'b000, 5'(m)});
         pins(1'b0, 5'(m), 1'b0);
         if (m == 0) begin
            wait_done(1);
            rd(a_st, 8'h00);
            raw <= 10'($random(seed));
         end
         wait_done(1);
         rd(a_st, {3'b100, 5'(m)});
         v = fmt(2'(m), raw);
         rd(a_hi, v[15:8]);
         rd(a_lo, v[7:0]);
         rd(a_st, {3'b000, 5'(m)});
      end
      foreach (codes[i]) begin
         wr(a_st, {3'b000, codes[i]});
         pins(1'b0, codes[i], 1'b0);
      end
      wr(a_st, 8'h1F);
      n = nst;
      repeat (60) @(posedge clk_in);
      pins(1'b1, 5'h1F, 1'b0);
      cmp("starts while off", n, nst);
      wr(a_ck, 8'h14);
      wr(a_st, 8'h23);
      wait_done(1);
      raw <= 10'($random(seed));
      wait_done(1);
      v = fmt(2'b01, raw);
      raw <= 10'($random(seed));
      rd(a_st, 8'hA3);
      rd(a_hi, v[15:8]);
      wait_done(1);
      raw <= 10'($random(seed));
      rd(a_lo, v[7:0]);
      wait_done(1);
      v = fmt(2'b01, raw);
      rd(a_hi, v[15:8]);
      rd(a_lo, v[7:0]);
      rd(a_st, 8'h23);
      for (int d = 0; d < 8; d++) begin
         wr(a_ck, {3'(d), 5'h14});
         gap(d < 4 ? 1 << d : 16);
      end
      wr(a_ck, 8'h24);
      gap(6);
      wr(a_ck, 8'h14);
      wr(a_st, 8'h03);
      // Skip a done left over from the aborted continuous conversion
      repeat (3) @(posedge clk_in);
      wait_done(1);
      n = nst;
      repeat (60) @(posedge clk_in);
      cmp("starts after single", n, nst);
      extra <= 8'h28;
      wr(a_st, 8'h02);
      repeat (10) @(posedge clk_in);
      n = nst;
      raw <= 10'($random(seed));
      wr(a_st, 8'h05);
      rd(a_st, 8'h05);
      wait_done(1);
      cmp("restarts", 8'(n + 8'h01), nst);
      v = fmt(2'b01, raw);
      rd(a_hi, v[15:8]);
      rd(a_lo, v[7:0]);
      extra <= 8'h00;
      wr(a_st, 8'h44);
      wait_done(1);
      pins(1'b0, 5'h04, 1'b1);
      rd(a_st, 8'h44);
      pins(1'b0, 5'h04, 1'b1);
      rd(a_lo, v[7:0]);
      pins(1'b0, 5'h04, 1'b0);
      wr(a_st, 8'hC4);
      rd(a_st, 8'hC4);
      wait_done(1);
      pins(1'b0, 5'h04, 1'b1);
      wr(a_st, 8'hE4);
      pins(1'b0, 5'h04, 1'b0);
      rst_b_in <= 1'b0;
      repeat (3) @(posedge clk_in);
      rst_b_in <= 1'b1;
      @(posedge clk_in);
      rd(a_st, 8'h1F);
      rd(a_ck, ck_rst);
      pins(1'b1, 5'h1F, 1'b0);
      stop_test();
   end
endmodule
